// ---- common/reconf_pkg.sv ----
/*
 * Constants shared by the reconfiguration control handler and its record store:
 * field sizes, message kind codes, cause strings and character codes.
 * Assumes strings travel with the first character in the most significant byte.
 */
`default_nettype none

package reconf_pkg;

    // ==========================================================
    // Field sizes, in characters.
    localparam int NAME_CHARS = 16;
    localparam int UTC_CHARS  = 8;
    localparam int FCT_CHARS  = 6;
    localparam int CAUSE_CHARS = 4;

    // ==========================================================
    // Incoming message kinds, all from the upstream entity.
    localparam logic [1:0] KIND_RECONF_REQ    = 2'h0;
    localparam logic [1:0] KIND_PENDING_QUERY = 2'h1;
    localparam logic [1:0] KIND_CANCEL        = 2'h2;

    // Outgoing message kinds, all from the downstream entity.
    localparam logic [1:0] RSP_TIMING_DEFINE  = 2'h0;
    localparam logic [1:0] RSP_ACK            = 2'h1;
    localparam logic [1:0] RSP_ERR            = 2'h2;

    // ==========================================================
    // Error causes as four ASCII characters, and CAUSE_IDLE as zero for no cause.
    localparam logic [31:0] CAUSE_NAME = 32'h4e414d45;
    localparam logic [31:0] CAUSE_INST = 32'h494e5354;
    localparam logic [31:0] CAUSE_PEND = 32'h50454e44;
    localparam logic [31:0] CAUSE_NRES = 32'h4e524553;
    localparam logic [31:0] CAUSE_NONE = 32'h4e4f4e45;
    localparam logic [31:0] CAUSE_LATE = 32'h4c415445;
    localparam logic [31:0] CAUSE_IDLE = 32'h00000000;

    // ==========================================================
    // Reserved monitoring names and the characters used by the checks.
    localparam logic [55:0] NAME_CURRENT = 56'h43555252454e54;
    localparam logic [4:0]  LEN_CURRENT  = 5'h07;
    localparam logic [31:0] NAME_NEXT    = 32'h4e455854;
    localparam logic [4:0]  LEN_NEXT     = 5'h04;
    localparam logic [7:0]  CHAR_ZERO    = 8'h30;
    localparam logic [7:0]  CHAR_ONE     = 8'h31;
    localparam logic [7:0]  CHAR_TWO     = 8'h32;
    localparam logic [7:0]  CHAR_THREE   = 8'h33;
    localparam logic [7:0]  CHAR_FOUR    = 8'h34;
    localparam logic [7:0]  CHAR_FIVE    = 8'h35;
    localparam logic [7:0]  CHAR_NINE    = 8'h39;
    localparam logic [7:0]  CHAR_COLON   = 8'h3a;

endpackage : reconf_pkg

`default_nettype wire

// ---- hw/reconf_record_store.sv ----
/*
 * Holding register for the single pending reconfiguration record.
 * The owner asks for load and clear together when a completion meets a new record; load wins.
 */
`timescale 1ns/1ps
`default_nettype none

module reconf_record_store
    import reconf_pkg::*;
#(
    parameter int NAME_W = 8 * NAME_CHARS,
    parameter int UTC_W  = 8 * UTC_CHARS,
    parameter int FCT_W  = 8 * FCT_CHARS
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              load,
    input  wire logic              clear,
    input  wire logic [NAME_W-1:0] name_in,
    input  wire logic [4:0]        name_len_in,
    input  wire logic [UTC_W-1:0]  utc_in,
    input  wire logic [FCT_W-1:0]  fct_in,
    output logic                   valid_r,
    output logic      [NAME_W-1:0] name_r,
    output logic      [4:0]        name_len_r,
    output logic      [UTC_W-1:0]  utc_r,
    output logic      [FCT_W-1:0]  fct_r
);

    // ==========================================================
    // Only one record exists, so a new load simply overwrites it.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
        end else if (load) begin
            valid_r <= 1'b1;
        end else if (clear) begin
            valid_r <= 1'b0;
        end
    end

    // The payload is left stale after a clear; only valid_r says it means anything.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            name_r     <= '0;
            name_len_r <= 5'h00;
            utc_r      <= '0;
            fct_r      <= '0;
        end else if (load) begin
            name_r     <= name_in;
            name_len_r <= name_len_in;
            utc_r      <= utc_in;
            fct_r      <= fct_in;
        end
    end

endmodule : reconf_record_store

`default_nettype wire

// ---- hw/reconfig_control_handler.sv ----
/*
 * Reconfiguration control message handler of the downstream entity.
 * Takes decoded requests (one per cycle) and answers each exactly one cycle later.
 * Assumes message framing, the configuration catalogue, instant feasibility,
 * resource checks and the actual switch-over live outside and report by inputs.
 */
// How it works
// - Every reconfiguration request gets exactly one answer: timing define or error.
// - The record becomes pending on the edge that issues the timing define.
// - A pending query returns the record, or error NONE when nothing pends.
// - A cancel is answered by acknowledge, or error when refused or nothing pends.
// - An accepted cancel clears the record and acknowledges on that same edge.
// - This block only emits timing define, acknowledge and error messages.
// - A well-formed imposed reconfiguration pends at once and is announced unsolicited if nothing pends and no request arrives with it.
// - Names are 1 to 16 characters; request names must also name a known configuration.
// - Time is HH:MM:SS with hours 00-23, minutes and seconds 00-59.
// - Frame count is UU:LLL with upper 00-19 and lower 000-249.
// - Request rejection causes are NAME, INST, PEND or NRES.
// - Cancel rejection causes are LATE, or NONE when nothing pends.
// - At most one reconfiguration is pending at any time.
// - A pending record stays until switch-over completes or a cancel is accepted.
// - The reserved names CURRENT and NEXT are never accepted.
`timescale 1ns/1ps
`default_nettype none

module reconfig_control_handler
    import reconf_pkg::*;
#(
    parameter int NAME_W = 8 * NAME_CHARS,
    parameter int UTC_W  = 8 * UTC_CHARS,
    parameter int FCT_W  = 8 * FCT_CHARS
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire logic [1:0]        req_kind,
    input  wire logic [NAME_W-1:0] req_name,
    input  wire logic [4:0]        req_name_len,
    input  wire logic [UTC_W-1:0]  req_utc,
    input  wire logic [FCT_W-1:0]  req_frame_count_stamp,
    input  wire logic              name_known,
    input  wire logic              instant_ok,
    input  wire logic              resource_ok,
    input  wire logic              cancel_late,
    input  wire logic              impose_valid,
    input  wire logic [NAME_W-1:0] impose_name,
    input  wire logic [4:0]        impose_name_len,
    input  wire logic [UTC_W-1:0]  impose_utc,
    input  wire logic [FCT_W-1:0]  impose_frame_count_stamp,
    input  wire logic              switch_done,
    output logic                   rsp_valid_r,
    output logic      [1:0]        rsp_kind_r,
    output logic      [31:0]       rsp_cause_r,
    output logic      [NAME_W-1:0] rsp_name_r,
    output logic      [4:0]        rsp_name_len_r,
    output logic      [UTC_W-1:0]  rsp_utc_r,
    output logic      [FCT_W-1:0]  rsp_frame_count_stamp_r,
    output logic                   pending_r
);

    // ==========================================================
    // Field format checks, shared by requests, imposed records and assertions.
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= CHAR_ZERO) && (c <= CHAR_NINE);
    endfunction : is_digit

    function automatic logic utc_ok(input logic [63:0] s);
        logic hh;
        logic mm;
        logic ss;
        hh = is_digit(s[63:56]) && is_digit(s[55:48]) && (s[63:56] <= CHAR_TWO)
             && ((s[63:56] < CHAR_TWO) || (s[55:48] <= CHAR_THREE));
        mm = is_digit(s[39:32]) && is_digit(s[31:24]) && (s[39:32] <= CHAR_FIVE);
        ss = is_digit(s[15:8]) && is_digit(s[7:0]) && (s[15:8] <= CHAR_FIVE);
        return hh && mm && ss && (s[47:40] == CHAR_COLON) && (s[23:16] == CHAR_COLON);
    endfunction : utc_ok

    function automatic logic fct_ok(input logic [47:0] s);
        logic hi;
        logic lo;
        hi = is_digit(s[47:40]) && is_digit(s[39:32]) && (s[47:40] <= CHAR_ONE);
        lo = is_digit(s[23:16]) && is_digit(s[15:8]) && is_digit(s[7:0])
             && (s[23:16] <= CHAR_TWO) && ((s[23:16] < CHAR_TWO) || (s[15:8] <= CHAR_FOUR));
        return hi && lo && (s[31:24] == CHAR_COLON);
    endfunction : fct_ok

    // Reserved monitoring names are refused even if the catalogue claims them.
    function automatic logic name_ok(input logic [127:0] n, input logic [4:0] len);
        logic reserved;
        reserved = ((len == LEN_CURRENT) && (n[127:72] == NAME_CURRENT))
                   || ((len == LEN_NEXT) && (n[127:96] == NAME_NEXT));
        return (len != 5'h00) && (len <= 5'(NAME_CHARS)) && !reserved;
    endfunction : name_ok

    // ==========================================================
    // Record store outputs.
    logic [NAME_W-1:0] rec_name;
    logic [4:0]        rec_name_len;
    logic [UTC_W-1:0]  rec_utc;
    logic [FCT_W-1:0]  rec_fct;

    // ==========================================================
    // Request decode. A completion in the same cycle ends the record first,
    // so a request then sees nothing pending.
    wire live       = pending_r && !switch_done;
    wire is_req     = req_valid && (req_kind == KIND_RECONF_REQ);
    wire is_query   = req_valid && (req_kind == KIND_PENDING_QUERY);
    wire is_cancel  = req_valid && (req_kind == KIND_CANCEL);
    wire bad_name   = !name_ok(req_name, req_name_len) || !name_known;
    wire bad_inst   = !utc_ok(req_utc) || !fct_ok(req_frame_count_stamp)
                      || !instant_ok;
    wire req_accept = is_req && !live && !bad_name && !bad_inst && resource_ok;
    wire can_accept = is_cancel && live && !cancel_late;
    wire imp_ok     = name_ok(impose_name, impose_name_len) && utc_ok(impose_utc)
                      && fct_ok(impose_frame_count_stamp);
    // An impose is dropped while a record pends or a request owns the answer slot.
    wire imp_accept = impose_valid && imp_ok && !live && !req_valid;

    // Rejection cause for a request, highest priority first.
    wire [31:0] req_cause = live     ? CAUSE_PEND :
                            bad_name ? CAUSE_NAME :
                            bad_inst ? CAUSE_INST : CAUSE_NRES;
    wire [31:0] can_cause = live ? CAUSE_LATE : CAUSE_NONE;

    // Answer selection: everything emitted is one of the three device kinds.
    wire        def_out   = req_accept || imp_accept || (is_query && live);
    wire [1:0]  kind_nxt  = def_out ? RSP_TIMING_DEFINE :
                            can_accept ? RSP_ACK : RSP_ERR;
    wire [31:0] cause_nxt = (def_out || can_accept) ? CAUSE_IDLE :
                            is_req ? req_cause :
                            is_query ? CAUSE_NONE : can_cause;
    wire        from_rec  = is_query;
    wire [NAME_W-1:0] name_nxt = from_rec ? rec_name : (imp_accept ? impose_name : req_name);
    wire [4:0]   len_nxt  = from_rec ? rec_name_len :
                            (imp_accept ? impose_name_len : req_name_len);
    wire [UTC_W-1:0] utc_nxt = from_rec ? rec_utc : (imp_accept ? impose_utc : req_utc);
    wire [FCT_W-1:0] fct_nxt = from_rec ? rec_fct :
                               (imp_accept ? impose_frame_count_stamp : req_frame_count_stamp);
    wire         rec_clear = can_accept || switch_done;

    // ==========================================================
    // The single pending record; its valid flag is the pending output.
    reconf_record_store #(
        .NAME_W (NAME_W),
        .UTC_W  (UTC_W),
        .FCT_W  (FCT_W)
    ) u_store (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .load        (req_accept || imp_accept),
        .clear       (rec_clear),
        .name_in     (imp_accept ? impose_name : req_name),
        .name_len_in (imp_accept ? impose_name_len : req_name_len),
        .utc_in      (imp_accept ? impose_utc : req_utc),
        .fct_in      (imp_accept ? impose_frame_count_stamp : req_frame_count_stamp),
        .valid_r     (pending_r),
        .name_r      (rec_name),
        .name_len_r  (rec_name_len),
        .utc_r       (rec_utc),
        .fct_r       (rec_fct)
    );

    // ==========================================================
    // Answer register: one answer per request, on the very next edge, so the
    // record and the message announcing it change together.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= req_valid || imp_accept;
        end
    end

    // Payload is held between answers; only rsp_valid_r qualifies it.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp_kind_r              <= RSP_ERR;
            rsp_cause_r             <= CAUSE_IDLE;
            rsp_name_r              <= '0;
            rsp_name_len_r          <= 5'h00;
            rsp_utc_r               <= '0;
            rsp_frame_count_stamp_r <= '0;
        end else if (req_valid || imp_accept) begin
            rsp_kind_r              <= kind_nxt;
            rsp_cause_r             <= cause_nxt;
            rsp_name_r              <= name_nxt;
            rsp_name_len_r          <= len_nxt;
            rsp_utc_r               <= utc_nxt;
            rsp_frame_count_stamp_r <= fct_nxt;
        end
    end

    // ==========================================================
    // Checks on the handler's own outputs.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_one_answer: assert property (req_valid |=> rsp_valid_r)
        else $error("request not answered on next edge");
    a_pend_on_define: assert property ($rose(pending_r)
        |-> rsp_valid_r && rsp_kind_r == RSP_TIMING_DEFINE)
        else $error("record pending without a timing define");
    a_query_none: assert property (is_query && !live
        |=> rsp_kind_r == RSP_ERR && rsp_cause_r == CAUSE_NONE)
        else $error("empty query not answered with NONE");
    a_cancel_clears: assert property (can_accept |=> rsp_kind_r == RSP_ACK && !pending_r)
        else $error("accepted cancel did not clear and acknowledge");
    a_cancel_late: assert property (is_cancel && live && cancel_late
        |=> rsp_cause_r == CAUSE_LATE && pending_r)
        else $error("late cancel not refused with LATE");
    a_reject_pend: assert property (is_req && live
        |=> rsp_cause_r == CAUSE_PEND && pending_r)
        else $error("second request not refused with PEND");
    a_record_holds: assert property (pending_r && !rec_clear
        |=> pending_r && $stable(rec_name))
        else $error("pending record changed without cause");
    a_impose_pends: assert property (imp_accept
        |=> pending_r && rsp_kind_r == RSP_TIMING_DEFINE)
        else $error("imposed reconfiguration not pending");
    // Kind and cause must agree: only an error answer carries a cause.
    a_device_kinds: assert property (rsp_valid_r |-> rsp_kind_r != 2'h3
        && ((rsp_kind_r == RSP_ERR) == (rsp_cause_r != CAUSE_IDLE)))
        else $error("illegal answer kind or cause");
    a_define_fields: assert property (rsp_valid_r && rsp_kind_r == RSP_TIMING_DEFINE
        |-> utc_ok(rsp_utc_r) && fct_ok(rsp_frame_count_stamp_r)
            && name_ok(rsp_name_r, rsp_name_len_r))
        else $error("timing define carries a malformed field");

    c_accept:  cover property (req_accept ##1 rsp_kind_r == RSP_TIMING_DEFINE);
    c_cancel:  cover property (can_accept ##1 rsp_kind_r == RSP_ACK);
    c_query:   cover property (is_query && live ##1 rsp_valid_r);
    c_impose:  cover property (imp_accept ##1 pending_r);

endmodule : reconfig_control_handler

`default_nettype wire

// ---- testbench/upstream_model.sv ----
/*
 * Behavioural model of the upstream control entity that feeds the handler.
 * Assumes the bench calls send() from a settled point between clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module upstream_model
    import reconf_pkg::*;
(
    input  wire logic                    mclk,
    output logic                         req_valid,
    output logic [1:0]                   req_kind,
    output logic [8*NAME_CHARS-1:0]      req_name,
    output logic [4:0]                   req_name_len,
    output logic [8*UTC_CHARS-1:0]       req_utc,
    output logic [8*FCT_CHARS-1:0]       req_frame_count_stamp
);
    // ==========================================================
    // Idle state at time zero.
    initial begin
        req_valid             = 1'b0;
        req_kind              = 2'h0;
        req_name              = '0;
        req_name_len          = 5'h00;
        req_utc               = '0;
        req_frame_count_stamp = '0;
    end

    // ==========================================================
    // One message, held for exactly one taking edge.
    // Only this side ever originates request, query and cancel messages.
    // Callers space messages so that every answer lands before acting on it.
    // Name, length, time and frame count are inverted once released, so a stale value is never mistaken for data.
    task automatic send(input logic [1:0] k, input logic [127:0] n, input logic [4:0] l,
                        input logic [63:0] u, input logic [47:0] f);
        @(posedge mclk);
        req_valid             <= 1'b1;
        req_kind              <= k;
        req_name              <= n;
        req_name_len          <= l;
        req_utc               <= u;
        req_frame_count_stamp <= f;
        @(posedge mclk);
        req_valid             <= 1'b0;
        req_name              <= ~n;
        req_name_len          <= ~l;
        req_utc               <= ~u;
        req_frame_count_stamp <= ~f;
    endtask : send
endmodule : upstream_model

`default_nettype wire

// ---- testbench/test_reconfig_control_handler.sv ----
/*
 * Self-checking bench for the reconfiguration control handler.
 * Assumes answers arrive on the same edge that takes the request.
 */
`timescale 1ns/1ps
`default_nettype none

module test_reconfig_control_handler
    import reconf_pkg::*;
;
    logic         mclk, rst_n, name_known, instant_ok, resource_ok, cancel_late;
    logic         impose_valid, switch_done, req_valid, rsp_valid_r, pending_r;
    logic [1:0]   req_kind, rsp_kind_r;
    logic [127:0] req_name, rsp_name_r;
    logic [4:0]   req_name_len, rsp_name_len_r;
    logic [63:0]  req_utc, rsp_utc_r;
    logic [47:0]  req_fct, rsp_fct_r;
    logic [31:0]  rsp_cause_r;
    int           err_total, check_count;

    localparam logic [127:0] NM_A  = {"CFGA", 96'h0};
    localparam logic [63:0]  UTC_A = "12:30:00";
    localparam logic [47:0]  FCT_A = "19:249";

    upstream_model u_up (.mclk(mclk), .req_valid(req_valid), .req_kind(req_kind),
        .req_name(req_name), .req_name_len(req_name_len), .req_utc(req_utc),
        .req_frame_count_stamp(req_fct));

    reconfig_control_handler uut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req_kind(req_kind), .req_name(req_name), .req_name_len(req_name_len),
        .req_utc(req_utc), .req_frame_count_stamp(req_fct), .name_known(name_known),
        .instant_ok(instant_ok), .resource_ok(resource_ok), .cancel_late(cancel_late),
        .impose_valid(impose_valid), .impose_name(NM_A), .impose_name_len(5'h04),
        .impose_utc(UTC_A), .impose_frame_count_stamp(FCT_A), .switch_done(switch_done),
        .rsp_valid_r(rsp_valid_r), .rsp_kind_r(rsp_kind_r), .rsp_cause_r(rsp_cause_r),
        .rsp_name_r(rsp_name_r), .rsp_name_len_r(rsp_name_len_r), .rsp_utc_r(rsp_utc_r),
        .rsp_frame_count_stamp_r(rsp_fct_r), .pending_r(pending_r));

    // ==========================================================
    // Clock at 10 MHz and a watchdog so that no hang goes unreported.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        err_total++;
        conclude();
    end

    // ==========================================================
    // Comparison helpers.
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Looks one step after the answering edge, where the registers have settled.
    task automatic expect_rsp(input logic [1:0] k, input logic [31:0] c, input logic p);
        #1;
        check("rsp_valid_r", 128'(rsp_valid_r), 128'h1);
        check("rsp_kind_r", 128'(rsp_kind_r), 128'(k));
        check("rsp_cause_r", 128'(rsp_cause_r), 128'(c));
        check("pending_r", 128'(pending_r), 128'(p));
    endtask : expect_rsp

    task automatic expect_record();
        check("rsp_name_r", rsp_name_r, NM_A);
        check("rsp_name_len_r", 128'(rsp_name_len_r), 128'h4);
        check("rsp_utc_r", 128'(rsp_utc_r), 128'(UTC_A));
        check("rsp_frame_count_stamp_r", 128'(rsp_fct_r), 128'(FCT_A));
    endtask : expect_record

    task automatic reject(input logic [127:0] n, input logic [4:0] l, input logic [63:0] u,
                          input logic [47:0] f, input logic [2:0] ok, input logic [31:0] c);
        @(posedge mclk);
        {name_known, instant_ok, resource_ok} <= ok;
        u_up.send(KIND_RECONF_REQ, n, l, u, f);
        expect_rsp(RSP_ERR, c, 1'b0);
    endtask : reject

    // ==========================================================
    // Scenarios.
    task automatic nothing_pending();
        u_up.send(KIND_PENDING_QUERY, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ERR, CAUSE_NONE, 1'b0);
        u_up.send(KIND_CANCEL, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ERR, CAUSE_NONE, 1'b0);
        u_up.send(2'h3, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ERR, CAUSE_NONE, 1'b0);
    endtask : nothing_pending

    task automatic bad_requests();
        reject(NM_A, 5'h04, UTC_A, FCT_A, 3'b011, CAUSE_NAME);
        reject({NAME_CURRENT, 72'h0}, LEN_CURRENT, UTC_A, FCT_A, 3'b111, CAUSE_NAME);
        reject({NAME_NEXT, 96'h0}, LEN_NEXT, UTC_A, FCT_A, 3'b111, CAUSE_NAME);
        reject(NM_A, 5'h00, UTC_A, FCT_A, 3'b111, CAUSE_NAME);
        reject(NM_A, 5'h11, UTC_A, FCT_A, 3'b111, CAUSE_NAME);
        reject(NM_A, 5'h04, "24:00:00", FCT_A, 3'b111, CAUSE_INST);
        reject(NM_A, 5'h04, "23:60:00", FCT_A, 3'b111, CAUSE_INST);
        reject(NM_A, 5'h04, UTC_A, "20:000", 3'b111, CAUSE_INST);
        reject(NM_A, 5'h04, UTC_A, "00:250", 3'b111, CAUSE_INST);
        reject(NM_A, 5'h04, UTC_A, FCT_A, 3'b101, CAUSE_INST);
        reject(NM_A, 5'h04, UTC_A, FCT_A, 3'b110, CAUSE_NRES);
    endtask : bad_requests

    // Accept, query, refuse a second, refuse a late cancel, then cancel in time.
    task automatic accept_and_cancel();
        @(posedge mclk);
        {name_known, instant_ok, resource_ok} <= 3'b111;
        u_up.send(KIND_RECONF_REQ, NM_A, 5'h04, "23:59:59", FCT_A);
        expect_rsp(RSP_TIMING_DEFINE, CAUSE_IDLE, 1'b1);
        check("rsp_utc_r", 128'(rsp_utc_r), 128'(64'("23:59:59")));
        // The query carries zero fields, so the answer must come from the record.
        u_up.send(KIND_PENDING_QUERY, '0, 5'h00, '0, '0);
        expect_rsp(RSP_TIMING_DEFINE, CAUSE_IDLE, 1'b1);
        check("rsp_name_r", rsp_name_r, NM_A);
        check("rsp_utc_r", 128'(rsp_utc_r), 128'(64'("23:59:59")));
        u_up.send(KIND_RECONF_REQ, NM_A, 5'h04, UTC_A, FCT_A);
        expect_rsp(RSP_ERR, CAUSE_PEND, 1'b1);
        @(posedge mclk);
        cancel_late <= 1'b1;
        u_up.send(KIND_CANCEL, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ERR, CAUSE_LATE, 1'b1);
        @(posedge mclk);
        cancel_late <= 1'b0;
        u_up.send(KIND_CANCEL, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ACK, CAUSE_IDLE, 1'b0);
        @(posedge mclk);
        #1;
        check("rsp_valid_r", 128'(rsp_valid_r), 128'h0);
    endtask : accept_and_cancel

    // An imposed reconfiguration pends at once; a second is dropped; completion clears it.
    task automatic impose_and_complete();
        check("pending_r", 128'(pending_r), 128'h0);
        @(posedge mclk);
        impose_valid <= 1'b1;
        @(posedge mclk);
        impose_valid <= 1'b0;
        expect_rsp(RSP_TIMING_DEFINE, CAUSE_IDLE, 1'b1);
        expect_record();
        @(posedge mclk);
        impose_valid <= 1'b1;
        @(posedge mclk);
        impose_valid <= 1'b0;
        #1;
        check("rsp_valid_r", 128'(rsp_valid_r), 128'h0);
        @(posedge mclk);
        switch_done <= 1'b1;
        @(posedge mclk);
        switch_done <= 1'b0;
        #1;
        check("pending_r", 128'(pending_r), 128'h0);
        u_up.send(KIND_PENDING_QUERY, '0, 5'h00, '0, '0);
        expect_rsp(RSP_ERR, CAUSE_NONE, 1'b0);
    endtask : impose_and_complete

    task automatic conclude();
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence.
    initial begin
        err_total = 0;
        check_count = 0;
        rst_n = 1'b0;
        {name_known, instant_ok, resource_ok, cancel_late} = 4'h0;
        impose_valid = 1'b0;
        switch_done = 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check("rsp_kind_r", 128'(rsp_kind_r), 128'(RSP_ERR));
        check("pending_r", 128'(pending_r), 128'h0);
        nothing_pending();
        bad_requests();
        accept_and_cancel();
        impose_and_complete();
        conclude();
    end
endmodule : test_reconfig_control_handler

`default_nettype wire
